// ==== octal_adc_control.sv ====
/*
  Digital control and CMOS serial port of an eight-channel simultaneous
  sampling converter: conversion timing, power down, timed global reset,
  auto nap, range register and circular 24-bit output packets.
  Assumes all pin inputs are asynchronous to clk_i and that the analog core
  delivers one word of eight results per conversion over result_valid_i.
*/
`timescale 1ns/10ps
module octal_adc_control #(
  parameter int WAKE_CYCLES = adc_ctrl_pkg::WAKE_CYC,
  parameter int GRST_CYCLES = adc_ctrl_pkg::GRST_CYC,
  parameter int BUF_DEPTH   = 2
) (
  input  wire logic                            clk_i,
  input  wire logic                            reset_i,
  input  wire logic                            power_down_in_i,
  input  wire logic                            sample_start_in_i,
  input  wire logic                            serial_clock_in_i,
  input  wire logic                            config_serial_in_i,
  input  wire logic                            chip_select_n_i,
  input  wire logic                            lvds_select_i,
  input  wire logic                            result_valid_i,
  input  wire logic [adc_ctrl_pkg::RES_W-1:0]  result_data_i,
  output logic                                 result_ready_o,
  output logic                                 sample_o,
  output logic                                 busy_o,
  output logic                                 nap_o,
  output logic                                 powered_down_o,
  output logic                                 reset_active_o,
  output logic                                 window_open_o,
  output logic                                 lvds_mode_o,
  output logic [adc_ctrl_pkg::CFG_BITS-1:0]    range_code_o,
  output logic [adc_ctrl_pkg::NUM_CH-1:0]      out_lane_o,
  output logic [adc_ctrl_pkg::NUM_CH-1:0]      out_lane_oe_o,
  output logic                                 echo_clock_out_o,
  output logic                                 echo_clock_out_oe_o
);
  import adc_ctrl_pkg::*;

  localparam int WAKE_W  = $clog2(WAKE_CYCLES + 1);
  localparam int TMAX    = (GRST_CYCLES > CONV_MAX_CYC) ? GRST_CYCLES : CONV_MAX_CYC;
  localparam int TIMER_W = $clog2(TMAX + 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CONV = 3'h2,
    ST_GRST = 3'h4
  } state_type;

  typedef struct packed {
    state_type                          state;
    logic [SYNC_W-1:0]                  sync1;
    logic [SYNC_W-1:0]                  sync2;
    logic [SYNC_W-1:0]                  prev;
    logic                               armed;
    logic [WAKE_W-1:0]                  wake_cnt;
    logic [TIMER_W-1:0]                 timer;
    logic                               window;
    logic                               nap;
    logic                               sample;
    logic [NUM_CH-1:0][RESULT_BITS-1:0] results;
    logic [CFG_BITS-1:0]                conv_range;
    logic [CFG_BITS-1:0]                range;
    logic [CFG_BITS-1:0]                cfg_shift;
    logic [4:0]                         cfg_cnt;
    logic [4:0]                         bit_idx;
    logic [2:0]                         pkt_idx;
    logic [NUM_CH-1:0]                  out_bits;
    logic                               echo;
  } core_type;

  localparam core_type CORE_RST = '{
    state:      ST_IDLE,
    sync1:      SYNC_RST,
    sync2:      SYNC_RST,
    prev:       SYNC_RST,
    wake_cnt:   WAKE_W'(WAKE_CYCLES),
    conv_range: CFG_DEFAULT,
    range:      CFG_DEFAULT,
    default:    '0
  };

  core_type q;
  core_type d;

  logic                               pd_s;
  logic                               pd_rise;
  logic                               start_rise;
  logic                               sck_rise;
  logic                               cs_n_s;
  logic                               lvds_s;
  logic                               grst_trig;
  logic                               conv_done;
  logic                               shift_en;
  logic                               cfg_done;
  logic [CFG_BITS-1:0]                cfg_word;
  logic [4:0]                         adv_bit;
  logic [2:0]                         adv_pkt;
  logic [NUM_CH-1:0]                  shift_bits;
  logic [NUM_CH-1:0][RESULT_BITS-1:0] new_results;
  logic [TIMER_W-1:0]                 conv_len;
  logic [NUM_CH-1:0]                  result_msb;

  result_buf_if #(.WIDTH(RES_W)) rbuf ();

  result_buffer #(
    .WIDTH (RES_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .bus     (rbuf)
  );

  assign rbuf.in_valid  = result_valid_i;
  assign rbuf.in_data   = result_data_i;
  assign rbuf.out_ready = conv_done;
  assign rbuf.flush     = grst_trig;
  assign result_ready_o = rbuf.in_ready;

  // only the second synchroniser stage and its delayed copy are read
  assign pd_s       = q.sync2[IX_PD];
  assign pd_rise    = pd_s & ~q.prev[IX_PD];
  assign start_rise = q.sync2[IX_CNV] & ~q.prev[IX_CNV];
  assign sck_rise   = q.sync2[IX_SCK] & ~q.prev[IX_SCK];
  assign cs_n_s     = q.sync2[IX_CSN];
  assign lvds_s     = q.sync2[IX_LVDS];

  assign grst_trig = pd_rise & q.armed & (q.state != ST_GRST);
  assign conv_done = (q.state == ST_CONV) && (q.timer == '0);
  assign shift_en  = sck_rise & ~cs_n_s & (q.state != ST_GRST);
  assign cfg_word  = {q.cfg_shift[CFG_BITS-2:0], q.sync2[IX_SDI]};
  assign cfg_done  = shift_en & q.window & (q.cfg_cnt == PKT_MSB);
  assign adv_bit   = (q.bit_idx == PKT_MSB) ? 5'h00 : q.bit_idx + 5'h01;
  assign adv_pkt   = q.pkt_idx + 3'((q.bit_idx == PKT_MSB) ? 1 : 0);
  assign new_results = rbuf.out_valid ? rbuf.out_data : '0;

  genvar k;
  generate
    for (k = 0; k < NUM_CH; k++)
    begin : g_lane
      logic [2:0]          ch;
      logic [PKT_BITS-1:0] pkt;
      assign ch  = 3'(k) + adv_pkt;
      assign pkt = {q.results[ch], 2'h0, ch, q.conv_range[3*ch +: 3]};
      assign shift_bits[k] = pkt[PKT_MSB - adv_bit];
      assign result_msb[k] = q.results[k][RESULT_BITS-1];
    end
  endgenerate

  // conversion length from the enabled channel count, counted from the pin edge
  always_comb
  begin
    int n;
    int t;
    n = 0;
    t = 0;
    for (int c = 0; c < NUM_CH; c++)
      if (q.range[3*c +: 3] != 3'h0)
        n = n + 1;
    if (n == 0)
      n = 1;
    t = (CONV_SLOPE_NS * n - CONV_OFFSET_NS) / CLK_PERIOD_NS - SYNC_LAT - 1;
    if (t < 0)
      t = 0;
    conv_len = TIMER_W'(t);
  end

  always_comb
  begin
    d = q;
    d.sync1  = {lvds_select_i, chip_select_n_i, config_serial_in_i,
                serial_clock_in_i, sample_start_in_i, power_down_in_i};
    d.sync2  = q.sync1;
    d.prev   = q.sync2;
    d.sample = 1'b0;

    if (q.wake_cnt != '0)
    begin
      d.wake_cnt = q.wake_cnt - WAKE_W'(1);
      if (q.wake_cnt == WAKE_W'(1) && q.state == ST_IDLE)
      begin
        d.window  = 1'b1;
        d.cfg_cnt = '0;
      end
    end

    if (shift_en)
    begin
      d.echo     = ~q.echo;
      d.bit_idx  = adv_bit;
      d.pkt_idx  = adv_pkt;
      d.out_bits = shift_bits;
      if (q.window)
      begin
        d.cfg_shift = cfg_word;
        d.cfg_cnt   = (q.cfg_cnt == PKT_MSB) ? 5'h00 : q.cfg_cnt + 5'h01;
        if (cfg_done && cfg_word != '0)
          d.range = cfg_word;
      end
    end

    case (q.state)
      ST_IDLE:
      begin
        if (start_rise && !pd_s)
        begin
          d.state      = ST_CONV;
          d.timer      = conv_len;
          d.sample     = 1'b1;
          d.nap        = 1'b0;
          d.window     = 1'b0;
          d.armed      = 1'b0;
          d.conv_range = q.range;
        end
      end
      ST_CONV:
      begin
        if (conv_done)
        begin
          d.state   = ST_IDLE;
          d.nap     = 1'b1;
          d.window  = 1'b1;
          d.cfg_cnt = '0;
          d.results = new_results;
          d.echo    = 1'b0;
          d.bit_idx = '0;
          d.pkt_idx = '0;
          for (int c = 0; c < NUM_CH; c++)
            d.out_bits[c] = new_results[c][RESULT_BITS-1];
        end
        else
          d.timer = q.timer - TIMER_W'(1);
      end
      ST_GRST:
      begin
        if (q.timer == '0)
        begin
          d.state    = ST_IDLE;
          d.wake_cnt = WAKE_W'(WAKE_CYCLES);
        end
        else
          d.timer = q.timer - TIMER_W'(1);
      end
      default:
        d.state = ST_IDLE;
    endcase

    if (grst_trig)
    begin
      d.state      = ST_GRST;
      d.timer      = TIMER_W'(GRST_CYCLES - 1);
      d.sample     = 1'b0;
      d.results    = '0;
      d.out_bits   = '0;
      d.range      = CFG_DEFAULT;
      d.conv_range = CFG_DEFAULT;
      d.window     = 1'b0;
      d.armed      = 1'b0;
      d.nap        = 1'b0;
      d.echo       = 1'b0;
      d.bit_idx    = '0;
      d.pkt_idx    = '0;
      d.cfg_cnt    = '0;
      d.wake_cnt   = '0;
    end
    else if (pd_rise)
      d.armed = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      q <= CORE_RST;
    else
      q <= d;
  end

  assign sample_o            = q.sample;
  assign busy_o              = (q.state == ST_CONV);
  assign nap_o               = q.nap;
  assign powered_down_o      = pd_s & (q.state != ST_CONV);
  assign reset_active_o      = (q.state == ST_GRST);
  assign window_open_o       = q.window;
  assign lvds_mode_o         = lvds_s;
  assign range_code_o        = q.range;
  assign out_lane_o          = q.out_bits;
  // LVDS mode keeps lane 0 only
  assign out_lane_oe_o       = cs_n_s ? '0 : (lvds_s ? 8'h01 : 8'hFF);
  assign echo_clock_out_o    = q.echo;
  assign echo_clock_out_oe_o = ~cs_n_s;

  localparam int CONV_MAX_A = 881;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  conv_time_a: assert property ($rose(busy_o) |-> ##[1:CONV_MAX_A] !busy_o)
    else $error("conversion too long");
  pd_block_a: assert property ((q.state == ST_IDLE && start_rise && pd_s && !grst_trig)
    |=> !busy_o)
    else $error("start taken while powered down");
  pd_finish_a: assert property ((busy_o && pd_rise && !grst_trig && q.timer != '0)
    |=> busy_o)
    else $error("conversion cut by power down");
  grst_start_a: assert property ((pd_rise && q.armed && !reset_active_o)
    |=> reset_active_o ##1 reset_active_o)
    else $error("global reset not entered");
  grst_clear_a: assert property ($rose(reset_active_o)
    |-> range_code_o == CFG_DEFAULT && out_lane_o == '0 && !window_open_o)
    else $error("reset did not clear state");
  grst_abort_a: assert property ((busy_o && grst_trig) |=> !busy_o && reset_active_o)
    else $error("conversion not aborted");
  nap_entry_a: assert property ($fell(busy_o) && !reset_active_o
    |-> nap_o && window_open_o)
    else $error("no nap or window after conversion");
  echo_load_a: assert property ($fell(busy_o) && !reset_active_o
    |-> !echo_clock_out_o && out_lane_o == result_msb)
    else $error("lanes or echo clock wrong at load");
  echo_tog_a: assert property ((shift_en && !conv_done && !grst_trig)
    |=> echo_clock_out_o != $past(echo_clock_out_o))
    else $error("echo clock did not toggle");
  bus_off_a: assert property (cs_n_s |-> out_lane_oe_o == '0 && !echo_clock_out_oe_o)
    else $error("bus driven while deselected");
  start_busy_a: assert property ((q.state == ST_IDLE && start_rise && !pd_s && !grst_trig)
    |=> busy_o && sample_o ##1 !sample_o)
    else $error("start did not raise busy");
  zero_word_a: assert property ((cfg_done && cfg_word == '0 && !grst_trig)
    |=> $stable(range_code_o))
    else $error("zero word changed range");

  conv_c: cover property ($rose(busy_o) ##[1:CONV_MAX_A] $fell(busy_o));
  grst_c: cover property ($rose(reset_active_o));
  cfg_c:  cover property (cfg_done && cfg_word != '0);
  wrap_c: cover property (shift_en && q.pkt_idx == 3'h7 && q.bit_idx == PKT_MSB);
endmodule

// ==== adc_ctrl_pkg.sv ====
/*
  Shared constants of the octal converter control block: channel and packet
  layout, reset values, synchroniser bit positions and timing counts.
  Assumes a 200 MHz system clock.
*/
package adc_ctrl_pkg;
  localparam int NUM_CH      = 8;
  localparam int RESULT_BITS = 16;
  localparam int RANGE_BITS  = 3;
  localparam int PKT_BITS    = 24;
  localparam int CFG_BITS    = 24;
  localparam int RES_W       = NUM_CH * RESULT_BITS;

  localparam logic [4:0]          PKT_MSB     = 5'h17;
  localparam logic [RANGE_BITS-1:0] RANGE_FULL = 3'h7;
  localparam logic [CFG_BITS-1:0] CFG_DEFAULT = {NUM_CH{RANGE_FULL}};

  // synchroniser bit positions
  localparam int IX_PD   = 0;
  localparam int IX_CNV  = 1;
  localparam int IX_SCK  = 2;
  localparam int IX_SDI  = 3;
  localparam int IX_CSN  = 4;
  localparam int IX_LVDS = 5;
  localparam int SYNC_W  = 6;
  // chip select idles high, so its synchroniser resets deselected
  localparam logic [SYNC_W-1:0] SYNC_RST = 6'h10;
  localparam int SYNC_LAT = 3;

  localparam int CLK_PERIOD_NS  = 5;
  localparam int CONV_SLOPE_NS  = 555;
  localparam int CONV_OFFSET_NS = 35;
  localparam int CONV_MAX_CYC   = (CONV_SLOPE_NS * NUM_CH - CONV_OFFSET_NS) / CLK_PERIOD_NS;
  localparam int WAKE_TIME_MS   = 10;
  localparam int WAKE_CYC       = WAKE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int GRST_TIME_NS   = 1000;
  localparam int GRST_CYC       = GRST_TIME_NS / CLK_PERIOD_NS;
endpackage

// ==== result_buf_if.sv ====
/*
  Valid/ready channel between the control logic and its result buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface result_buf_if #(parameter int WIDTH = 128);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  logic             flush;
  modport store (input in_valid, in_data, out_ready, flush,
                 output in_ready, out_valid, out_data);
  modport user  (output in_valid, in_data, out_ready, flush,
                 input in_ready, out_valid, out_data);
endinterface

// ==== result_buffer.sv ====
/*
  Small FIFO holding converter result words until the control logic takes
  them. Assumes DEPTH is a power of two and synchronous active-high reset.
*/
`timescale 1ns/10ps
module result_buffer #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  result_buf_if.store       bus
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } fifo_type;

  fifo_type q;
  fifo_type d;
  logic     push;
  logic     pop;

  assign bus.in_ready  = (q.cnt != CW'(DEPTH));
  assign bus.out_valid = (q.cnt != '0);
  assign bus.out_data  = q.mem[q.rd];
  assign push = bus.in_valid & bus.in_ready;
  assign pop  = bus.out_valid & bus.out_ready;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr] = bus.in_data;
      d.wr = q.wr + PW'(1);
    end
    if (pop)
      d.rd = q.rd + PW'(1);
    d.cnt = q.cnt + CW'(push) - CW'(pop);
    if (bus.flush)
    begin
      d.wr  = '0;
      d.rd  = '0;
      d.cnt = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      q <= '0;
    else
      q <= d;
  end
endmodule

// ==== host_model.sv ====
/*
  Host side of the serial port: framed serial clock, config input and chip
  select, capturing all eight lanes before each serial clock rise.
  Assumes the bench resolves lane enables into lane_i.
*/
`timescale 1ns/10ps
module host_model (
  input  wire logic [7:0] lane_i,
  input  wire logic [7:0] lane_oe_i,
  input  wire logic       echo_i,
  output logic            sck_o,
  output logic            sdi_o,
  output logic            cs_n_o
);
  logic [47:0] cap [8];
  logic [7:0]  oe_seen;
  int          echo_bad;
  initial
  begin
    sck_o = 1'b0;
    sdi_o = 1'b1;
    cs_n_o = 1'b1;
    echo_bad = 0;
  end
  // 125 ns serial clock, well under the ceiling; clock stands low between frames
  task automatic frame(input logic [23:0] cfg, input int nbits);
    cs_n_o = 1'b0;
    #60;
    oe_seen = lane_oe_i;
    for (int i = 0; i < nbits; i++)
    begin
      sdi_o = cfg[23 - (i % 24)];
      #60;
      for (int k = 0; k < 8; k++)
      begin
        cap[k] = {cap[k][46:0], lane_i[k]};
      end
      if (echo_i !== 1'(i % 2))
        echo_bad++;
      sck_o = 1'b1;
      #65;
      sck_o = 1'b0;
    end
    #65;
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask
endmodule

// ==== octal_adc_control_tb.sv ====
/*
  Self-checking bench for the octal converter control block.
  Assumes host_model.sv and the shared package.
*/
`timescale 1ns/10ps
module octal_adc_control_tb;
  import adc_ctrl_pkg::*;
  localparam int WAKE = 50;
  localparam int GRST = 20, ACQ = 113;
  typedef struct packed {
    logic [23:0] cfg;
    logic [23:0] rng;
  } row_type;
  logic             clk_i = 1'b0, reset_i = 1'b1, pd = 1'b0, start = 1'b0;
  logic             lvds = 1'b0, rvalid = 1'b0;
  logic [RES_W-1:0] rdata = '0, res;
  logic             rready, sample, busy, nap, pdn, rst_act, win, lvds_m;
  logic             echo, echo_oe, sck, config_serial_in, csn;
  logic [23:0]      rng, rat;
  logic [7:0]       lane, lane_oe, lane_w;
  int               failures = 0, check_count = 0, cycles = 0, len, len2;
  row_type          rows [4] = '{'{24'hFFFFFF, 24'hFFFFFF}, '{24'h249249, 24'h249249},
                                 '{24'h000000, 24'h249249}, '{24'h00003F, 24'h00003F}};
  always #2.5 clk_i = ~clk_i;
  for (genvar k = 0; k < 8; k++)
  begin : g_w
    assign lane_w[k] = lane_oe[k] ? lane[k] : 1'bz;
  end
  octal_adc_control #(.WAKE_CYCLES(WAKE), .GRST_CYCLES(GRST), .BUF_DEPTH(2)) octal_adc_control_i (
    .clk_i(clk_i), .reset_i(reset_i), .power_down_in_i(pd), .sample_start_in_i(start),
    .serial_clock_in_i(sck), .config_serial_in_i(config_serial_in), .chip_select_n_i(csn),
    .lvds_select_i(lvds), .result_valid_i(rvalid), .result_data_i(rdata),
    .result_ready_o(rready), .sample_o(sample), .busy_o(busy), .nap_o(nap),
    .powered_down_o(pdn), .reset_active_o(rst_act), .window_open_o(win),
    .lvds_mode_o(lvds_m), .range_code_o(rng), .out_lane_o(lane), .out_lane_oe_o(lane_oe),
    .echo_clock_out_o(echo), .echo_clock_out_oe_o(echo_oe));
  host_model host_model_i (.lane_i(lane_w), .lane_oe_i(lane_oe), .echo_i(echo),
    .sck_o(sck), .sdi_o(config_serial_in), .cs_n_o(csn));
  task automatic check48(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check48({47'h0, got}, {47'h0, exp});
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      give_verdict();
    end
  end
  function automatic int busy_len(input logic [23:0] r);
    int n;
    n = 0;
    for (int c = 0; c < 8; c++)
      n += (r[3*c +: 3] != 3'h0);
    return (555 * n - 35) / 5 - 3;
  endfunction
  function automatic logic [47:0] pkts(input logic [127:0] d, input logic [23:0] r, input int k);
    int j;
    j = (k + 1) % 8;
    return {d[16*k +: 16], 2'b00, 3'(k), r[3*k +: 3], d[16*j +: 16], 2'b00, 3'(j), r[3*j +: 3]};
  endfunction
  function automatic logic [127:0] mk(input int r);
    logic [127:0] d;
    for (int k = 0; k < 8; k++)
      d[16*k +: 16] = {4'hC, 4'(r), 4'(k), 4'hA};
    return d;
  endfunction
  task automatic wait_win();
    for (int w = 0; w < 200 && win !== 1'b1; w++) @(negedge clk_i);
  endtask
  task automatic push(input logic [127:0] d);
    rvalid = 1'b1;
    rdata = d;
    for (int w = 0; w < 20 && rready !== 1'b1; w++) @(negedge clk_i);
    @(negedge clk_i);
    rvalid = 1'b0;
  endtask
  // start pulse held until busy shows; n is the busy length, 0 when refused
  task automatic conv(output int n);
    n = 0;
    start = 1'b1;
    for (int w = 0; w < 20 && busy !== 1'b1; w++) @(negedge clk_i);
    start = 1'b0;
    if (busy === 1'b1)
      check1(sample, 1'b1);
    while (busy === 1'b1 && n < 2000)
    begin
      n++;
      @(negedge clk_i);
    end
  endtask
  initial
  begin
    repeat (6) @(negedge clk_i);
    reset_i = 1'b0;
    check48(48'(rng), 48'hFFFFFF);
    repeat (20) @(negedge clk_i);
    check1(win, 1'b0);
    for (int r = 0; r < 4; r++)
    begin
      wait_win();
      check1(win, 1'b1);
      host_model_i.frame(rows[r].cfg, 48);
      @(negedge clk_i);
      for (int k = 0; k < 8 && r > 0; k++)
        check48(host_model_i.cap[k], pkts(res, rat, k));
      check48(48'(host_model_i.echo_bad), 48'h0);
      check48(48'(host_model_i.oe_seen), 48'hFF);
      repeat (8) @(negedge clk_i);
      check48(48'(rng), 48'(rows[r].rng));
      check1(lane_oe === 8'h00 && echo_oe === 1'b0, 1'b1);
      res = mk(r);
      rat = rows[r].rng;
      push(res);
      conv(len);
      check48(48'(len), 48'(busy_len(rat)));
      repeat (ACQ) @(negedge clk_i);
      check1(nap, 1'b1);
      check1(win, 1'b1);
      $display("row %0d done", r);
    end
    fork
      conv(len);
      begin
        repeat (60) @(negedge clk_i);
        pd = 1'b1;
        repeat (6) @(negedge clk_i);
        check1(pdn, 1'b0);
      end
    join
    check48(48'(len), 48'(busy_len(24'h00003F)));
    repeat (4) @(negedge clk_i);
    check1(pdn, 1'b1);
    conv(len);
    check48(48'(len), 48'h0);
    pd = 1'b0;
    repeat (WAKE + ACQ) @(negedge clk_i);
    conv(len);
    $display("power down done");
    host_model_i.frame(24'h000249, 10);
    repeat (8) @(negedge clk_i);
    check48(48'(rng), 48'h00003F);
    $display("partial word done");
    rvalid = 1'b1;
    rdata = mk(5);
    repeat (2) @(negedge clk_i);
    check1(rready, 1'b0);
    rvalid = 1'b0;
    conv(len);
    repeat (ACQ) @(negedge clk_i);
    check1(rready, 1'b1);
    $display("buffer done");
    fork
      conv(len);
      begin
        repeat (40) @(negedge clk_i);
        pd = 1'b1;
        repeat (10) @(negedge clk_i);
        pd = 1'b0;
        repeat (10) @(negedge clk_i);
        pd = 1'b1;
        len2 = 0;
        for (int w = 0; w < 10 && rst_act !== 1'b1; w++) @(negedge clk_i);
        while (rst_act === 1'b1 && len2 < 500)
        begin
          len2++;
          @(negedge clk_i);
        end
      end
    join
    check1(len < 100, 1'b1);
    check48(48'(len2), 48'(GRST));
    check48(48'(rng), 48'hFFFFFF);
    check48(48'(lane), 48'h0);
    check1(pdn, 1'b1);
    pd = 1'b0;
    wait_win();
    check1(win, 1'b1);
    $display("global reset done");
    lvds = 1'b1;
    repeat (6) @(negedge clk_i);
    host_model_i.frame(24'h000000, 24);
    check48(48'(host_model_i.oe_seen), 48'h01);
    check1(lvds_m, 1'b1);
    $display("lvds done");
    give_verdict();
  end
endmodule
